// ===== hw/gprc_gpio_top.sv
// Purpose: pin mode control, output source selection and regulator enables
// Assumes: deep_sleep comes from logic on hclk; single-word AHB-Lite access
// Notes:   no wait states; unmapped addresses read zero, answer OKAY
// Behaviour
// - internal regulators off during deep sleep
// - pull external regulator pin low in sleep
// - 24 pins, each with its own mode
// - input reaches input register, peripherals in every mode but analog
// - wake gated by enable, interrupt by capability
// - analog mode forces digital input high
// - one output source per pin at once
// - output from data register or peripheral
// - input and analog modes disable driver
// - four-bit mode per pin, low/high registers
// - decode analog, float, pull; out bit picks
// - decode output and alternate output codes
// - alternate without peripheral drives zero
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module gprc_gpio_top
	import gprc_pkg::*;
#(
	parameter logic [NUM_PINS-1:0] ALT_PRESENT = 24'hFFFFFF,
	parameter logic [NUM_PINS-1:0] IRQ_CAPABLE = 24'hFFFFFF
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output var  logic                hreadyout,
	output var  logic                hresp,
	output var  logic [31:0]         hrdata,
	input  wire logic [NUM_PINS-1:0] pin_in,
	output var  logic [NUM_PINS-1:0] pin_out,
	output var  logic [NUM_PINS-1:0] pin_oe,
	output var  logic [NUM_PINS-1:0] pin_pull_en,
	output var  logic [NUM_PINS-1:0] pin_pull_up,
	output var  logic [NUM_PINS-1:0] pin_analog,
	input  wire logic [NUM_PINS-1:0] alt_out,
	output var  logic [NUM_PINS-1:0] alt_in,
	output var  logic [NUM_PINS-1:0] wake_in,
	output var  logic [NUM_PINS-1:0] irq_in,
	input  wire logic                deep_sleep,
	output var  logic                vreg_1v8_en,
	output var  logic                vreg_1v25_en,
	output var  logic                ext_reg_en_out,
	output var  logic                ext_reg_en_oe
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [NUM_PINS*MODE_BITS-1:0] cfg_ff, nxt_cfg;
	logic [NUM_PINS-1:0]           out_ff, nxt_out;
	logic [NUM_PINS-1:0]           wake_ff, nxt_wake;
	logic                          regctl_ff, nxt_regctl;
	logic [ADDR_W-1:0]             addr_ff;
	logic                          wr_ff;
	logic [NUM_PINS-1:0]           pin_out_ff, pin_oe_ff;
	logic [NUM_PINS-1:0]           pull_en_ff, pull_up_ff, analog_ff;
	logic                          vreg_ff, ext_oe_ff;
	logic [NUM_PINS-1:0]           sync_q, in_val;
	logic [NUM_PINS-1:0]           drv, alt, od, ana, pull, src;
	logic [31:0]                   rd_data;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire        addr_phase = hsel && hready && htrans[1];
	wire [1:0]  sel_port   = addr_ff[PORT_LSB+1:PORT_LSB];
	wire [2:0]  sel_idx    = addr_ff[PORT_LSB-1:IDX_LSB];
	wire        glob_hit   = sel_port == PORT_GLOBAL && sel_idx == IDX_REGCTL;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ff <= '0;
			wr_ff   <= 1'b0;
		end else if (hready) begin
			addr_ff <= haddr[ADDR_W-1:0];
			wr_ff   <= addr_phase && hwrite;
		end
	end

	// ---------------------------------------------------------------
	// per-pin mode decode
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			drv[i]  = gprc_is_drv(cfg_ff[i*MODE_BITS +: MODE_BITS]);
			alt[i]  = gprc_is_alt(cfg_ff[i*MODE_BITS +: MODE_BITS]);
			od[i]   = gprc_is_od(cfg_ff[i*MODE_BITS +: MODE_BITS]);
			ana[i]  = cfg_ff[i*MODE_BITS +: MODE_BITS] == MODE_ANALOG;
			pull[i] = cfg_ff[i*MODE_BITS +: MODE_BITS] == MODE_IN_PULL;
		end
	end

	// single mux: peripheral or data register, never both
	assign src = (alt & alt_out & ALT_PRESENT) | (~alt & out_ff);

	// ---------------------------------------------------------------
	// input path
	// ---------------------------------------------------------------
	gprc_sync #(
		.WIDTH (NUM_PINS)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (pin_in),
		.q       (sync_q)
	);

	assign in_val  = sync_q | ana;
	assign alt_in  = in_val;
	assign wake_in = in_val & wake_ff;
	assign irq_in  = in_val & IRQ_CAPABLE;

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	always_comb begin
		nxt_cfg    = cfg_ff;
		nxt_out    = out_ff;
		nxt_wake   = wake_ff;
		nxt_regctl = regctl_ff;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (wr_ff && sel_port == 2'(p)) begin
				case (sel_idx)
					IDX_CFGL: nxt_cfg[p*32 +: CFG_HALF] = hwdata[15:0];
					IDX_CFGH: nxt_cfg[p*32+CFG_HALF +: CFG_HALF] = hwdata[15:0];
					IDX_OUT:  nxt_out[p*8 +: 8] = hwdata[7:0];
					IDX_SET:  nxt_out[p*8 +: 8] = out_ff[p*8 +: 8] | hwdata[7:0];
					IDX_CLR:  nxt_out[p*8 +: 8] = out_ff[p*8 +: 8] & ~hwdata[7:0];
					IDX_WAKE: nxt_wake[p*8 +: 8] = hwdata[7:0];
					default:  nxt_out = nxt_out;
				endcase
			end
		end
		if (wr_ff && glob_hit) begin
			nxt_regctl = hwdata[REGCTL_EN];
		end
	end

	// ---------------------------------------------------------------
	// register reads
	// ---------------------------------------------------------------
	always_comb begin
		rd_data = 32'h00000000;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (sel_port == 2'(p)) begin
				case (sel_idx)
					IDX_CFGL: rd_data[15:0] = cfg_ff[p*32 +: CFG_HALF];
					IDX_CFGH: rd_data[15:0] = cfg_ff[p*32+CFG_HALF +: CFG_HALF];
					IDX_IN:   rd_data[7:0] = in_val[p*8 +: 8];
					IDX_OUT:  rd_data[7:0] = out_ff[p*8 +: 8];
					IDX_WAKE: rd_data[7:0] = wake_ff[p*8 +: 8];
					default:  rd_data = 32'h00000000;
				endcase
			end
		end
		if (glob_hit) begin
			rd_data[REGCTL_EN] = regctl_ff;
			rd_data[REGCTL_DS] = deep_sleep;
		end
	end

	assign hrdata = rd_data;

	// ---------------------------------------------------------------
	// storage and pin drivers
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff    <= {NUM_PINS{CFG_RST}};
			out_ff    <= {NUM_PORTS{OUT_RST}};
			wake_ff   <= {NUM_PORTS{WAKE_RST}};
			regctl_ff <= REGCTL_RST;
		end else begin
			cfg_ff    <= nxt_cfg;
			out_ff    <= nxt_out;
			wake_ff   <= nxt_wake;
			regctl_ff <= nxt_regctl;
		end
	end

	// registered drivers cost a cycle but keep pads glitch free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out_ff <= '0;
			pin_oe_ff  <= '0;
			pull_en_ff <= '0;
			pull_up_ff <= '0;
			analog_ff  <= '0;
			vreg_ff    <= 1'b0;
			ext_oe_ff  <= 1'b0;
		end else begin
			pin_out_ff <= src & drv & ~od;
			pin_oe_ff  <= drv & ~(od & src);
			pull_en_ff <= pull;
			pull_up_ff <= pull & out_ff;
			analog_ff  <= ana;
			vreg_ff    <= regctl_ff && !deep_sleep;
			ext_oe_ff  <= deep_sleep;
		end
	end

	assign pin_out        = pin_out_ff;
	assign pin_oe         = pin_oe_ff;
	assign pin_pull_en    = pull_en_ff;
	assign pin_pull_up    = pull_up_ff;
	assign pin_analog     = analog_ff;
	assign vreg_1v8_en    = vreg_ff;
	assign vreg_1v25_en   = vreg_ff;
	assign ext_reg_en_out = 1'b0;
	assign ext_reg_en_oe  = ext_oe_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic [1:0] age_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			age_ff <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	vreg_sleep_off_a: assert property (deep_sleep |=> !vreg_1v8_en && !vreg_1v25_en)
		else $error("regulator on in deep sleep");
	vreg_wake_on_a: assert property (!deep_sleep && regctl_ff |=> vreg_1v8_en)
		else $error("regulator off when awake");
	ext_reg_pull_a: assert property (deep_sleep |=> ext_reg_en_oe && !ext_reg_en_out)
		else $error("external enable not pulled low");
	ext_reg_free_a: assert property (!deep_sleep |=> !ext_reg_en_oe)
		else $error("external enable not released");
	no_drive_in_a: assert property (##1 (pin_oe & $past(~drv)) == '0)
		else $error("driver on in input or analog mode");
	analog_high_a: assert property (age_ff == 2'h3 |-> (in_val & ana) == ana)
		else $error("analog pin input not high");
	alt_none_a: assert property (##1 (pin_out & $past(alt & ~ALT_PRESENT)) == '0)
		else $error("alternate pin without peripheral not zero");
	out_reg_src_a: assert property (
		##1 ((pin_out ^ $past(out_ff)) & $past(drv & ~alt & ~od)) == '0)
		else $error("normal output not from data register");
	od_never_high_a: assert property (##1 (pin_out & $past(od)) == '0)
		else $error("open drain pin driven high");
	wake_gate_a: assert property ((wake_in & ~wake_ff) == '0)
		else $error("wake passed on disabled pin");
	sync_delay_a: assert property (
		age_ff == 2'h3 |-> ((alt_in ^ $past(pin_in, 2)) & ~ana) == '0)
		else $error("input not two cycles behind pin");
	pull_dir_a: assert property (##1 pin_pull_up == $past(pull & out_ff))
		else $error("pull direction wrong");

	sleep_entry_c: cover property (!deep_sleep ##1 deep_sleep);
	alt_drive_c:   cover property (|(alt & drv & alt_out));
	analog_c:      cover property (|ana);
	cfg_write_c:   cover property (wr_ff && sel_idx == IDX_CFGL);
endmodule : gprc_gpio_top
`default_nettype wire

// ===== hw/gprc_pkg.sv
// Purpose: shared constants and mode decode for the pin control block
// Assumes: 24 pins in three ports of eight, four mode bits per pin
// Notes:   register indices are word indices, byte address is index * 4
package gprc_pkg;
	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int NUM_PINS  = 24;
	localparam int NUM_PORTS = 3;
	localparam int PORT_PINS = 8;
	localparam int MODE_BITS = 4;
	localparam int CFG_HALF  = 16;
	localparam int ADDR_W    = 8;
	localparam int SYNC_W    = 2;

	// ---------------------------------------------------------------
	// register map: port in haddr[6:5], register in haddr[4:2]
	// ---------------------------------------------------------------
	localparam logic [1:0] PORT_GLOBAL = 2'h3;
	localparam logic [2:0] IDX_CFGL    = 3'h0;
	localparam logic [2:0] IDX_CFGH    = 3'h1;
	localparam logic [2:0] IDX_IN      = 3'h2;
	localparam logic [2:0] IDX_OUT     = 3'h3;
	localparam logic [2:0] IDX_SET     = 3'h4;
	localparam logic [2:0] IDX_CLR     = 3'h5;
	localparam logic [2:0] IDX_WAKE    = 3'h6;
	localparam logic [2:0] IDX_REGCTL  = 3'h0;
	localparam int         PORT_LSB    = 5;
	localparam int         IDX_LSB     = 2;
	localparam int         REGCTL_EN   = 0;
	localparam int         REGCTL_DS   = 1;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [3:0]  CFG_RST    = 4'h4;
	localparam logic [7:0]  OUT_RST    = 8'h00;
	localparam logic [7:0]  WAKE_RST   = 8'h00;
	localparam logic        REGCTL_RST = 1'b1;

	// ---------------------------------------------------------------
	// mode codes
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_ANALOG   = 4'h0,
		MODE_OUT_PP   = 4'h1,
		MODE_IN_FLOAT = 4'h4,
		MODE_OUT_OD   = 4'h5,
		MODE_IN_PULL  = 4'h8,
		MODE_ALT_PP   = 4'h9,
		MODE_ALT_SCLK = 4'hB,
		MODE_ALT_OD   = 4'hD
	} gprc_mode_t;

	function automatic logic gprc_is_alt(input logic [3:0] c);
		return c == MODE_ALT_PP || c == MODE_ALT_OD || c == MODE_ALT_SCLK;
	endfunction : gprc_is_alt

	function automatic logic gprc_is_od(input logic [3:0] c);
		return c == MODE_OUT_OD || c == MODE_ALT_OD;
	endfunction : gprc_is_od

	function automatic logic gprc_is_drv(input logic [3:0] c);
		return c == MODE_OUT_PP || c == MODE_OUT_OD || gprc_is_alt(c);
	endfunction : gprc_is_drv
endpackage : gprc_pkg

// ===== hw/gprc_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to hclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module gprc_sync #(
	parameter int WIDTH = 24
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : gprc_sync
`default_nettype wire

// ===== dv/gprc_pad_model.sv
// Purpose: pad and board model for the pin control block
// Assumes: board drivers are weaker than the block's own driver
// Notes:   an undriven, unpulled pad toggles each cycle, never holds
`timescale 1ns/10ps
`default_nettype none
module gprc_pad_model
	import gprc_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic [NUM_PINS-1:0] pin_out,
	input  wire logic [NUM_PINS-1:0] pin_oe,
	input  wire logic [NUM_PINS-1:0] pin_pull_en,
	input  wire logic [NUM_PINS-1:0] pin_pull_up,
	input  wire logic [NUM_PINS-1:0] ext_drv,
	input  wire logic [NUM_PINS-1:0] ext_val,
	input  wire logic                ext_reg_en_out,
	input  wire logic                ext_reg_en_oe,
	output var  logic [NUM_PINS-1:0] pin_lvl,
	output var  logic                ext_reg_pad
);
	logic [NUM_PINS-1:0] drift = 24'hA5C3F0;
	logic [NUM_PINS-1:0] idle;
	always @(posedge hclk) drift <= ~drift;
	assign idle = (pin_pull_en & pin_pull_up) | (~pin_pull_en & drift);
	assign pin_lvl = (pin_oe & pin_out)
		| (~pin_oe & ((ext_drv & ext_val) | (~ext_drv & idle)));
	// board pull-up releases the enable line high
	assign ext_reg_pad = ext_reg_en_oe ? ext_reg_en_out : 1'b1;
endmodule : gprc_pad_model
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench for the pin control block
// Assumes: single word AHB-Lite master, one idle cycle between transfers
// Notes:   random data from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %0t %s", $time, m); end end
module tb;
	import gprc_pkg::*;
	localparam logic [23:0] ALT_P = 24'hFFFF7F;
	localparam logic [23:0] IRQ_C = 24'h7FFFFF;
	localparam logic [3:0] MODES [9] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5,
		4'h9, 4'hB, 4'hD, 4'h2};
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic        deep_sleep = 0, hreadyout, hresp, ext_reg_pad;
	logic        vreg_1v8_en, vreg_1v25_en, ext_reg_en_out, ext_reg_en_oe;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h7A5E;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [23:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_up;
	logic [23:0] pin_analog, alt_in, wake_in, irq_in;
	logic [23:0] alt_out = 0, ext_drv = 24'hFFFFFF, ext_val = 0;
	logic [3:0]  cfg_sh [24];
	logic [7:0]  out_sh [3], wake_sh [3];
	int          failures = 0, checked = 0, cyc = 0;

	always #12.5 hclk = ~hclk;

	gprc_gpio_top #(.ALT_PRESENT(ALT_P), .IRQ_CAPABLE(IRQ_C)) gprc_gpio_top_i (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .pin_in, .pin_out,
		.pin_oe, .pin_pull_en, .pin_pull_up, .pin_analog, .alt_out, .alt_in,
		.wake_in, .irq_in, .deep_sleep, .vreg_1v8_en, .vreg_1v25_en,
		.ext_reg_en_out, .ext_reg_en_oe);
	gprc_pad_model gprc_pad_model_i (.hclk, .pin_out, .pin_oe, .pin_pull_en,
		.pin_pull_up, .ext_drv, .ext_val, .ext_reg_en_out, .ext_reg_en_oe,
		.pin_lvl(pin_in), .ext_reg_pad);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		logic [31:0] s;
		s = seed;
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		seed = s;
		return s;
	endfunction : rnd

	function automatic logic [7:0] ad(input logic [1:0] pt, input logic [2:0] ix);
		return {1'b0, pt, ix, 2'b00};
	endfunction : ad

	function automatic logic [31:0] cw(input logic [1:0] pt, input logic h);
		logic [31:0] w;
		w = 32'h0;
		for (int k = 0; k < 4; k++) w[4*k +: 4] = cfg_sh[pt*8 + h*4 + k];
		return w;
	endfunction : cw

	// {oe, out, pull_en, pull_up, analog}; pad without peripheral reads 0
	function automatic logic [4:0] exp_pad(input logic [3:0] c,
		input logic ob, input logic ab, input logic ap);
		logic v;
		v = (c == 4'h9 || c == 4'hB || c == 4'hD) ? (ab & ap) : ob;
		case (c)
			4'h0: return 5'b00001;
			4'h1, 4'h9, 4'hB: return {1'b1, v, 3'b000};
			4'h5, 4'hD: return {~v, 4'b0000};
			4'h8: return {2'b00, 1'b1, ob, 1'b0};
			default: return 5'b00000;
		endcase
	endfunction : exp_pad

	// one idle cycle before each transfer keeps the driver simple
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask : bus

	task automatic results();
		if (failures == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		int p;
		logic [1:0] pt;
		logic [2:0] b;
		logic [3:0] c;
		logic [4:0] e;
		logic x;
		foreach (cfg_sh[i]) cfg_sh[i] = CFG_RST;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		`CHK(pin_oe, 24'h0, "oe at reset")
		@(negedge hclk);
		`CHK({vreg_1v8_en, vreg_1v25_en, ext_reg_en_oe}, 3'b110, "awake")
		`CHK(ext_reg_pad, 1'b1, "ext pad released")
		bus(8'h20, 0, 0, rd);
		`CHK(rd, 32'h4444, "cfg reset")
		bus(8'h7C, 0, 0, rd);
		`CHK(rd, 32'h0, "unmapped")
		`CHK({hreadyout, hresp}, 2'b10, "okay response")
		ext_val[23] <= 1'b1;
		@(negedge hclk);
		@(negedge hclk);
		`CHK(alt_in[23], 1'b0, "sync early")
		@(negedge hclk);
		`CHK(alt_in[23], 1'b1, "sync late")
		`CHK({irq_in[23], wake_in[23]}, 2'b00, "gating")
		for (int i = 0; i < 18; i++) begin
			c = MODES[i % 9];
			p = (i >= 14) ? 7 : int'(rnd() % 24);
			pt = 2'(p / 8);
			b = 3'(p % 8);
			out_sh[pt] = 8'(rnd());
			wake_sh[pt] = 8'(rnd());
			bus(ad(pt, IDX_OUT), 1, {24'h0, out_sh[pt]}, rd);
			bus(ad(pt, IDX_WAKE), 1, {24'h0, wake_sh[pt]}, rd);
			alt_out <= 24'(rnd());
			ext_val <= 24'(rnd());
			cfg_sh[p] = c;
			bus(ad(pt, b[2] ? IDX_CFGH : IDX_CFGL), 1, cw(pt, b[2]), rd);
			repeat (3) @(posedge hclk);
			@(negedge hclk);
			e = exp_pad(c, out_sh[pt][b], alt_out[p], ALT_P[p]);
			`CHK({pin_oe[p], pin_out[p], pin_pull_en[p], pin_pull_up[p],
				pin_analog[p]}, e, "pad mode")
			x = (c == 4'h0) ? 1'b1 : e[4] ? e[3] : ext_val[p];
			`CHK(alt_in[p], x, "alt in")
			`CHK(wake_in[p], x & wake_sh[pt][b], "wake")
			`CHK(irq_in[p], x & IRQ_C[p], "irq")
			bus(ad(pt, IDX_IN), 0, 0, rd);
			`CHK(rd[b], x, "in reg")
			bus(ad(pt, b[2] ? IDX_CFGH : IDX_CFGL), 0, 0, rd);
			`CHK(rd, cw(pt, b[2]), "cfg read")
		end
		bus(ad(2'h0, IDX_OUT), 1, 32'h0000000F, rd);
		bus(ad(2'h0, IDX_SET), 1, 32'h00000030, rd);
		bus(ad(2'h0, IDX_CLR), 1, 32'h00000005, rd);
		bus(ad(2'h0, IDX_OUT), 0, 0, rd);
		`CHK(rd, 32'h0000003A, "set and clear")
		bus(ad(2'h0, IDX_SET), 0, 0, rd);
		`CHK(rd, 32'h00000000, "set reads zero")
		bus(8'h60, 1, 32'h0, rd);
		// enable register lands at the data edge, driver one edge later
		@(posedge hclk);
		@(negedge hclk);
		`CHK({vreg_1v8_en, vreg_1v25_en}, 2'b00, "sw off")
		bus(8'h60, 1, 32'h1, rd);
		deep_sleep <= 1'b1;
		@(posedge hclk);
		@(negedge hclk);
		`CHK({vreg_1v8_en, vreg_1v25_en}, 2'b00, "sleep")
		`CHK(ext_reg_pad, 1'b0, "ext pad low")
		bus(8'h60, 0, 0, rd);
		`CHK(rd, 32'h3, "regctl")
		deep_sleep <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
		`CHK({vreg_1v8_en, vreg_1v25_en}, 2'b11, "wake up")
		`CHK(ext_reg_pad, 1'b1, "ext pad up")
		results();
	end
endmodule : tb
`default_nettype wire
